// *** rtl/svd_pkg.sv ***
// shared constants of the supply-voltage detector control block
// Functional notes
// - detector powered only while enable bit set
// - reference-stable flag low until settled, gating events
// - direction bit: clear watches drops, set rises
// - equality with trip point counts as detection
// - four-bit level code selects sixteen trip points
// - code 1111 routes external trip input
// - crossing in chosen direction sets event flag
// - flag cannot set before settle interval ends
// - settle interval timed from independent timebase
// - read-only bandgap-stable flag reports reference state
// - flag and enable bit 2; global enable gates
// - detector keeps running in sleep, wakes device
// - any reset returns control register to off
package svd_pkg;

  localparam int SVD_ADDR_W = 4;
  localparam int SVD_DATA_W = 8;
  localparam int SVD_LEVEL_W = 4;
  localparam int SVD_SYNC_W = 4;

  // register offsets
  localparam logic [3:0] SVD_OFF_CTRL = 4'h0;
  localparam logic [3:0] SVD_OFF_IRQ_STAT = 4'h1;
  localparam logic [3:0] SVD_OFF_IRQ_CLR = 4'h2;
  localparam logic [3:0] SVD_OFF_IRQ_EN = 4'h3;
  localparam logic [3:0] SVD_OFF_CORE_IRQ = 4'h4;

  // voltage_detect_control field positions
  localparam int SVD_DIR_BIT = 7;
  localparam int SVD_BG_BIT = 6;
  localparam int SVD_REF_BIT = 5;
  localparam int SVD_EN_BIT = 4;
  localparam int SVD_LEVEL_LSB = 0;

  // interrupt register field positions
  localparam int SVD_FLAG_BIT = 2;
  localparam int SVD_GIE_BIT = 7;

  // value after reset and code of the external trip input
  localparam logic [7:0] SVD_CTRL_RESET = 8'h05;
  localparam logic [3:0] SVD_LEVEL_EXT = 4'hF;

  // settle interval in timebase ticks, not in clock cycles
  localparam int SVD_SETTLE_W = 16;
  localparam logic [15:0] SVD_SETTLE_TICKS = 16'h0014;

endpackage

// *** rtl/svd_sync2.sv ***
// two-flop synchroniser for asynchronous pins
`timescale 1ns/10ps
`default_nettype none
module svd_sync2
  import svd_pkg::*;
#(
  parameter int W = SVD_SYNC_W
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } svd_sync_s;

  svd_sync_s st_reg;
  svd_sync_s st_next;

  always_comb begin
    st_next.meta = i_async;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_sync = st_reg.sync;

endmodule
`default_nettype wire

// *** rtl/svd_settle_timer.sv ***
// reference settle timer counting ticks of an independent timebase
`timescale 1ns/10ps
`default_nettype none
module svd_settle_timer
  import svd_pkg::*;
#(
  parameter logic [SVD_SETTLE_W-1:0] SETTLE_TICKS = SVD_SETTLE_TICKS
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire logic i_tick_sync,
  output logic o_done
);

  typedef struct packed {
    logic tick_prev;
    logic [SVD_SETTLE_W-1:0] cnt;
    logic done;
  } svd_timer_s;

  svd_timer_s st_reg;
  svd_timer_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick_prev = i_tick_sync;
    if (!i_run) begin
      // every enable starts a fresh interval
      st_next.cnt = '0;
      st_next.done = 1'b0;
    end else if (!st_reg.done && i_tick_sync && !st_reg.tick_prev) begin
      if (st_reg.cnt >= SETTLE_TICKS - 1'b1) begin
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_done = st_reg.done;

endmodule
`default_nettype wire

// *** rtl/svd_ctrl.sv ***
// control, status and interrupt logic of the supply threshold detector
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module svd_ctrl
  import svd_pkg::*;
#(
  parameter logic [SVD_SETTLE_W-1:0] SETTLE_TICKS = SVD_SETTLE_TICKS
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [SVD_ADDR_W-1:0] i_addr,
  input wire logic [SVD_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [SVD_DATA_W-1:0] o_rdata,
  input wire logic i_cmp_at_or_above,
  input wire logic i_cmp_at_or_below,
  input wire logic i_bandgap_stable,
  input wire logic i_timebase_tick,
  input wire logic i_sleep,
  output logic o_detector_power_en,
  output logic [SVD_LEVEL_W-1:0] o_trip_level_code,
  output logic o_external_trip_sel,
  output logic o_crossing_direction_sel,
  output logic o_irq,
  output logic o_wake
);

  typedef struct packed {
    logic dir;
    logic en;
    logic [SVD_LEVEL_W-1:0] level;
    logic ext_sel;
    logic flag;
    logic irq_en;
    logic gie;
    logic [SVD_DATA_W-1:0] rdata;
    logic irq;
    logic wake;
  } svd_state_s;

  localparam svd_state_s SVD_ST_RESET = '{
    dir: SVD_CTRL_RESET[SVD_DIR_BIT],
    en: SVD_CTRL_RESET[SVD_EN_BIT],
    level: SVD_CTRL_RESET[SVD_LEVEL_LSB +: SVD_LEVEL_W],
    ext_sel: 1'b0,
    flag: 1'b0,
    irq_en: 1'b0,
    gie: 1'b0,
    rdata: 8'h00,
    irq: 1'b0,
    wake: 1'b0
  };

  svd_state_s st_reg;
  svd_state_s st_next;

  logic [SVD_SYNC_W-1:0] pins_sync;
  logic above_s;
  logic below_s;
  logic bg_s;
  logic tick_s;
  logic ref_stable;
  logic hit;
  logic event_set;

  svd_sync2 #(
    .W(SVD_SYNC_W)
  ) u_sync (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_timebase_tick, i_bandgap_stable,
              i_cmp_at_or_below, i_cmp_at_or_above}),
    .o_sync(pins_sync)
  );

  assign above_s = pins_sync[0];
  assign below_s = pins_sync[1];
  assign bg_s = pins_sync[2];
  assign tick_s = pins_sync[3];

  svd_settle_timer #(
    .SETTLE_TICKS(SETTLE_TICKS)
  ) u_settle (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(st_reg.en),
    .i_tick_sync(tick_s),
    .o_done(ref_stable)
  );

  // compose the readable view of a register
  function automatic logic [SVD_DATA_W-1:0] read_mux(
    input logic [SVD_ADDR_W-1:0] addr,
    input svd_state_s s,
    input logic bg,
    input logic refs
  );
    logic [SVD_DATA_W-1:0] v;
    v = '0;
    unique case (addr)
      SVD_OFF_CTRL: begin
        v[SVD_DIR_BIT] = s.dir;
        v[SVD_BG_BIT] = bg;
        v[SVD_REF_BIT] = refs;
        v[SVD_EN_BIT] = s.en;
        v[SVD_LEVEL_LSB +: SVD_LEVEL_W] = s.level;
      end
      SVD_OFF_IRQ_STAT: begin
        v[SVD_FLAG_BIT] = s.flag;
      end
      SVD_OFF_IRQ_EN: begin
        v[SVD_FLAG_BIT] = s.irq_en;
      end
      SVD_OFF_CORE_IRQ: begin
        v[SVD_GIE_BIT] = s.gie;
      end
      // clear register is write-only, unmapped reads as zero
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction

  assign hit = st_reg.dir ? above_s : below_s;

  assign event_set = st_reg.en && ref_stable && hit;

  always_comb begin
    st_next = st_reg;

    if (i_wr) begin
      unique case (i_addr)
        SVD_OFF_CTRL: begin
          st_next.dir = i_wdata[SVD_DIR_BIT];
          st_next.en = i_wdata[SVD_EN_BIT];
          st_next.level = i_wdata[SVD_LEVEL_LSB +: SVD_LEVEL_W];
        end
        SVD_OFF_IRQ_CLR: begin
          if (i_wdata[SVD_FLAG_BIT]) begin
            st_next.flag = 1'b0;
          end
        end
        SVD_OFF_IRQ_EN: begin
          st_next.irq_en = i_wdata[SVD_FLAG_BIT];
        end
        SVD_OFF_CORE_IRQ: begin
          st_next.gie = i_wdata[SVD_GIE_BIT];
        end
        default: begin
          st_next.dir = st_reg.dir;
        end
      endcase
    end

    if (event_set) begin
      st_next.flag = 1'b1;
    end

    st_next.ext_sel = (st_next.level == SVD_LEVEL_EXT);

    st_next.irq = st_next.flag && st_next.irq_en && st_next.gie;

    // wake does not depend on interrupt enables
    st_next.wake = i_sleep && st_next.flag;

    // read data stand one cycle only
    if (i_rd) begin
      st_next.rdata = read_mux(i_addr, st_reg, bg_s, ref_stable);
    end else begin
      st_next.rdata = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= SVD_ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_detector_power_en = st_reg.en;
  assign o_trip_level_code = st_reg.level;
  assign o_external_trip_sel = st_reg.ext_sel;
  assign o_crossing_direction_sel = st_reg.dir;
  assign o_irq = st_reg.irq;
  assign o_wake = st_reg.wake;

endmodule
`default_nettype wire

// *** sim/svd_ctrl_properties.sv ***
// concurrent checks on the detector control block ports
`timescale 1ns/10ps
`default_nettype none
module svd_ctrl_properties
  import svd_pkg::*;
#(
  parameter logic [SVD_SETTLE_W-1:0] SETTLE_TICKS = SVD_SETTLE_TICKS
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [SVD_ADDR_W-1:0] i_addr,
  input wire logic [SVD_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [SVD_DATA_W-1:0] o_rdata,
  input wire logic i_bandgap_stable,
  input wire logic i_sleep,
  input wire logic o_detector_power_en,
  input wire logic [SVD_LEVEL_W-1:0] o_trip_level_code,
  input wire logic o_external_trip_sel,
  input wire logic o_crossing_direction_sel,
  input wire logic o_irq,
  input wire logic o_wake
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_wr_ctrl;
    i_wr && i_addr == SVD_OFF_CTRL;
  endsequence
  sequence s_rd_ctrl;
    i_rd && i_addr == SVD_OFF_CTRL;
  endsequence
  a_ctrl_from_wr:
  assert property (s_wr_ctrl |=> o_detector_power_en == $past(i_wdata[4])
    && o_crossing_direction_sel == $past(i_wdata[7])
    && o_trip_level_code == $past(i_wdata[3:0])) else $error("ctrl write");
  a_ext_sel_code:
  assert property (o_external_trip_sel == (o_trip_level_code == 4'hF))
    else $error("external select");
  a_reset_off:
  assert property ($past(i_sys_rst) |-> !o_detector_power_en && !o_irq
    && o_trip_level_code == 4'h5) else $error("reset state");
  a_wake_in_sleep:
  assert property (o_wake |-> $past(i_sleep)) else $error("wake");
  a_irq_gate_off:
  assert property (i_wr && ((i_addr == SVD_OFF_IRQ_EN && !i_wdata[2])
    || (i_addr == SVD_OFF_CORE_IRQ && !i_wdata[7])) |=> !o_irq)
    else $error("irq gate");
  a_ctrl_readback:
  assert property (s_rd_ctrl |=> o_rdata[3:0] == o_trip_level_code
    && o_rdata[4] == o_detector_power_en
    && o_rdata[7] == o_crossing_direction_sel) else $error("readback");
  a_bandgap_read:
  assert property ($stable(i_bandgap_stable)[*4] ##0 s_rd_ctrl
    |=> o_rdata[6] == $past(i_bandgap_stable)) else $error("bandgap");
  a_ref_off_read:
  assert property (!o_detector_power_en[*2] ##1 s_rd_ctrl |=> !o_rdata[5])
    else $error("ref flag");
endmodule
bind svd_ctrl svd_ctrl_properties #(.SETTLE_TICKS(SETTLE_TICKS)) u_chk (
  .i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_bandgap_stable, .i_sleep, .o_detector_power_en, .o_trip_level_code,
  .o_external_trip_sel, .o_crossing_direction_sel, .o_irq, .o_wake);
`default_nettype wire

// *** sim/svd_ctrl_tb.sv ***
// self-checking bench for the detector control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  err_total++; $display("ERROR %s exp %h got %h", n, e, g); end end
module svd_ctrl_tb
  import svd_pkg::*;
;
  logic i_clk = 0, rst = 1, wr = 0, rd = 0, ab = 0, be = 0;
  logic bg = 0, tk = 0, sl = 0, pw, ex, dr, irq, wk;
  logic [3:0] ad = 4'h0, lv;
  logic [7:0] wd = 8'h00, rdat;
  int err_total = 0, tests_run = 0;
  svd_ctrl #(.SETTLE_TICKS(16'h0002)) i_dut (.i_clk(i_clk),
    .i_sys_rst(rst), .i_addr(ad), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdat), .i_cmp_at_or_above(ab), .i_cmp_at_or_below(be),
    .i_bandgap_stable(bg), .i_timebase_tick(tk), .i_sleep(sl),
    .o_detector_power_en(pw), .o_trip_level_code(lv),
    .o_external_trip_sel(ex), .o_crossing_direction_sel(dr),
    .o_irq(irq), .o_wake(wk));
  initial forever #2 i_clk = ~i_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wrr(input logic [3:0] a, input logic [7:0] d);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, string n);
    ad <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    #1 `CHK(n, e, rdat)
    cyc(1);
  endtask
  // slow timebase: edges far apart so the synchroniser sees each
  task automatic tick(input int n);
    repeat (n) begin
      tk <= 1'b1;
      cyc(3);
      tk <= 1'b0;
      cyc(3);
    end
  endtask
  task automatic t_reset;
    `CHK("pwr", 1'b0, pw)
    `CHK("lvl", 4'h5, lv)
    rdc(SVD_OFF_CTRL, 8'h05, "ctrl");
    rdc(4'h9, 8'h00, "unmapped");
    bg <= 1'b1;
    cyc(4);
    rdc(SVD_OFF_CTRL, 8'h45, "bg");
    $display("t_reset done");
  endtask
  task automatic t_ctrl;
    wrr(SVD_OFF_CTRL, 8'h9E);
    `CHK("pwr", 1'b1, pw)
    `CHK("dir", 1'b1, dr)
    `CHK("lvl", 4'hE, lv)
    `CHK("ext", 1'b0, ex)
    rdc(SVD_OFF_CTRL, 8'hDE, "ctrl");
    wrr(SVD_OFF_CTRL, 8'h6F);
    `CHK("ext", 1'b1, ex)
    `CHK("pwr", 1'b0, pw)
    rdc(SVD_OFF_CTRL, 8'h4F, "ro bits");
    $display("t_ctrl done");
  endtask
  task automatic t_settle;
    // level and direction, then enable, then clear stale flag
    wrr(SVD_OFF_CTRL, 8'h05);
    wrr(SVD_OFF_CTRL, 8'h15);
    wrr(SVD_OFF_IRQ_CLR, 8'h04);
    be <= 1'b1;
    cyc(40);
    rdc(SVD_OFF_IRQ_STAT, 8'h00, "early");
    rdc(SVD_OFF_CTRL, 8'h55, "unsettled");
    tick(2);
    cyc(4);
    rdc(SVD_OFF_CTRL, 8'h75, "settled");
    rdc(SVD_OFF_IRQ_STAT, 8'h04, "drop");
    $display("t_settle done");
  endtask
  task automatic t_irq;
    wrr(SVD_OFF_IRQ_EN, 8'h04);
    `CHK("irq", 1'b0, irq)
    wrr(SVD_OFF_CORE_IRQ, 8'h80);
    `CHK("irq", 1'b1, irq)
    be <= 1'b0;
    cyc(4);
    rdc(SVD_OFF_IRQ_STAT, 8'h04, "sticky");
    wrr(SVD_OFF_IRQ_CLR, 8'h04);
    rdc(SVD_OFF_IRQ_STAT, 8'h00, "clear");
    `CHK("irq", 1'b0, irq)
    $display("t_irq done");
  endtask
  task automatic t_dir;
    wrr(SVD_OFF_CTRL, 8'h05);
    wrr(SVD_OFF_CTRL, 8'h95);
    be <= 1'b1;
    tick(2);
    cyc(4);
    rdc(SVD_OFF_IRQ_STAT, 8'h00, "rise");
    sl <= 1'b1;
    ab <= 1'b1;
    cyc(5);
    `CHK("wake", 1'b1, wk)
    `CHK("irq", 1'b1, irq)
    sl <= 1'b0;
    wrr(SVD_OFF_CORE_IRQ, 8'h00);
    `CHK("irq", 1'b0, irq)
    $display("t_dir done");
  endtask
  task automatic t_rst;
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    `CHK("pwr", 1'b0, pw)
    // bandgap synchroniser restarts from zero, let the pin pass through
    cyc(2);
    rdc(SVD_OFF_CTRL, 8'h45, "ctrl");
    rdc(SVD_OFF_IRQ_EN, 8'h00, "irq en");
    rdc(SVD_OFF_IRQ_STAT, 8'h00, "flag");
    $display("t_rst done");
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_ctrl();
    t_settle();
    t_irq();
    t_dir();
    t_rst();
    close_out();
  end
  initial begin
    #20000;
    err_total++;
    close_out();
  end
endmodule
`default_nettype wire
